// [src/branch_target_unit.v]
// Branch target arithmetic for relative, paged and long branches
`include "operand_addressing_defs.vh"

module branch_target_unit #(
    parameter PC_WIDTH = 16
) (
    // Program counter of the following instruction
    input  wire [PC_WIDTH-1:0] next_pc_i,
    // Operand bytes
    input  wire [7:0]          rel_offset_i,
    input  wire [10:0]         paged_target_i,
    input  wire [15:0]         long_target_i,
    // Targets
    output wire [PC_WIDTH-1:0] rel_target_o,
    output wire [PC_WIDTH-1:0] paged_target_o,
    output wire [PC_WIDTH-1:0] long_target_o
);

    wire [PC_WIDTH-1:0] rel_ext;

    // Sign extend, then let the sum wrap at the counter width
    assign rel_ext      = {{(PC_WIDTH-8){rel_offset_i[7]}}, rel_offset_i};
    assign rel_target_o = next_pc_i + rel_ext;

    // Upper page bits come from the following instruction
    assign paged_target_o = {next_pc_i[PC_WIDTH-1:11], paged_target_i};
    assign long_target_o  = long_target_i[PC_WIDTH-1:0];

endmodule

// [src/cpu_operand_addressing.v]
// Operand addressing and data pointer registers of the processor core
`include "operand_addressing_defs.vh"

module cpu_operand_addressing #(
    parameter PC_WIDTH = 16
) (
    // Clock and reset
    input  wire                clock_i,
    input  wire                sys_rst_i,
    // Instruction being decoded
    input  wire [7:0]          opcode_i,
    input  wire [7:0]          operand1_i,
    input  wire [7:0]          operand2_i,
    input  wire [PC_WIDTH-1:0] next_pc_i,
    input  wire [1:0]          bank_select_i,
    input  wire [7:0]          pointer_r0_i,
    input  wire [7:0]          pointer_r1_i,
    // Special-function bus
    input  wire [7:0]          sfr_addr_i,
    input  wire [7:0]          sfr_wdata_i,
    input  wire                sfr_wr_i,
    input  wire                sfr_rd_i,
    input  wire [3:0]          sfr_page_i,
    output reg  [7:0]          sfr_rdata_o,
    output reg                 sfr_hit_o,
    // Resolved operand
    output reg  [2:0]          operand_kind_o,
    output reg  [7:0]          operand_addr_o,
    output reg  [2:0]          operand_bit_o,
    output reg                 no_operation_o,
    // Branch resolution
    output reg                 branch_valid_o,
    output reg                 branch_is_call_o,
    output reg  [PC_WIDTH-1:0] branch_target_o,
    // Data pointer
    output wire [15:0]         data_pointer_o
);

    // ==========================================================
    // Decode helpers
    function is_bank_reg;
        input [7:0] op;
        begin
            is_bank_reg = (op[3] == 1'b1) && (op[7:4] != 4'h0)
                && (op[7:4] != 4'h8) && (op[7:4] != 4'ha)
                && (op[7:4] != 4'hb);
        end
    endfunction

    function is_indirect;
        input [7:0] op;
        begin
            is_indirect = (op[3:1] == 3'b011) && (op[7:4] != 4'h0)
                && (op[7:4] != 4'h8) && (op[7:4] != 4'ha)
                && (op[7:4] != 4'hb) && (op[7:4] != 4'hd);
        end
    endfunction

    // Only carry and bit instructions; ADD/ADDC direct must stay direct
    function is_bit_op;
        input [7:0] op;
        begin
            is_bit_op = (op == `OPC_JUMP_BIT_SET)
                || (op == `OPC_JUMP_BIT_CLEAR)
                || (op == `OPC_JUMP_BIT_CLEAR_SET)
                || (op == `OPC_CARRY_OR_NOT_BIT)
                || (op == `OPC_CARRY_AND_NOT_BIT)
                || ((op[3:0] == `BIT_OP_LOW_NIBBLE)
                    && (op[7:4] >= `BIT_OP_ROW_FIRST)
                    && (op[7:4] <= `BIT_OP_ROW_LAST));
        end
    endfunction

    // Bit-addressed space: RAM bytes 0x20-0x2f, SFRs on multiples of 8
    function [7:0] bit_byte_addr;
        input [7:0] bit_addr;
        begin
            if (bit_addr[7]) begin
                bit_byte_addr = {bit_addr[7:3], 3'b000};
            end else begin
                bit_byte_addr = {4'h2, bit_addr[6:3]};
            end
        end
    endfunction

    // ==========================================================
    // Data pointer registers
    reg  [7:0] dp_low_reg;
    reg  [7:0] dp_high_reg;
    wire       hit_low;
    wire       hit_high;

    // Page number is ignored: both bytes sit on every page
    assign hit_low  = (sfr_addr_i == `DATA_POINTER_LOW_ADDR);
    assign hit_high = (sfr_addr_i == `DATA_POINTER_HIGH_ADDR);
    assign data_pointer_o = {dp_high_reg, dp_low_reg};

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dp_low_reg  <= `DATA_POINTER_RESET;
            dp_high_reg <= `DATA_POINTER_RESET;
        end else begin
            if (sfr_wr_i && hit_low) begin
                dp_low_reg <= sfr_wdata_i;
            end
            if (sfr_wr_i && hit_high) begin
                dp_high_reg <= sfr_wdata_i;
            end
        end
    end

    // Registered read data, one cycle after the strobe
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o   <= 1'b0;
        end else if (sfr_rd_i) begin
            sfr_hit_o <= hit_low | hit_high;
            if (hit_low) begin
                sfr_rdata_o <= dp_low_reg;
            end else if (hit_high) begin
                sfr_rdata_o <= dp_high_reg;
            end else begin
                sfr_rdata_o <= 8'h00;
            end
        end else begin
            sfr_hit_o <= 1'b0;
        end
    end

    // ==========================================================
    // Branch targets
    wire [PC_WIDTH-1:0] rel_target;
    wire [PC_WIDTH-1:0] paged_target;
    wire [PC_WIDTH-1:0] long_target;
    reg  [7:0]          rel_byte;
    reg                 is_rel;
    reg                 is_paged;
    reg                 is_long;

    branch_target_unit #(
        .PC_WIDTH (PC_WIDTH)
    ) u_targets (
        .next_pc_i      (next_pc_i),
        .rel_offset_i   (rel_byte),
        .paged_target_i ({opcode_i[7:5], operand1_i}),
        .long_target_i  ({operand1_i, operand2_i}),
        .rel_target_o   (rel_target),
        .paged_target_o (paged_target),
        .long_target_o  (long_target)
    );

    always @* begin
        is_rel   = 1'b0;
        rel_byte = operand1_i;
        case (opcode_i)
            `OPC_SHORT_JUMP, `OPC_JUMP_IF_CARRY, `OPC_JUMP_NOT_CARRY,
            `OPC_JUMP_IF_ZERO, `OPC_JUMP_NOT_ZERO: begin
                is_rel = 1'b1;
            end
            `OPC_DEC_JUMP_DIRECT, `OPC_JUMP_BIT_SET, `OPC_JUMP_BIT_CLEAR,
            `OPC_JUMP_BIT_CLEAR_SET: begin
                is_rel   = 1'b1;
                rel_byte = operand2_i;
            end
            default: begin
                // Compare-and-jump and register decrement-and-jump
                if (opcode_i[7:4] == 4'hb && opcode_i[3:0] >= 4'h4) begin
                    is_rel   = 1'b1;
                    rel_byte = operand2_i;
                end else if (opcode_i[7:3] == 5'b11011) begin
                    is_rel = 1'b1;
                end
            end
        endcase
        is_paged = (opcode_i[3:0] == `PAGED_LOW_NIBBLE);
        is_long  = (opcode_i == `OPC_LONG_JUMP)
                || (opcode_i == `OPC_LONG_CALL);
    end

    // ==========================================================
    // Operand resolution, registered
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            operand_kind_o   <= `KIND_NONE;
            operand_addr_o   <= 8'h00;
            operand_bit_o    <= 3'h0;
            no_operation_o   <= 1'b0;
            branch_valid_o   <= 1'b0;
            branch_is_call_o <= 1'b0;
            branch_target_o  <= {PC_WIDTH{1'b0}};
        end else begin
            operand_bit_o    <= 3'h0;
            branch_valid_o   <= 1'b0;
            branch_is_call_o <= 1'b0;
            branch_target_o  <= {PC_WIDTH{1'b0}};
            no_operation_o   <= 1'b0;
            operand_kind_o   <= `KIND_NONE;
            operand_addr_o   <= 8'h00;
            if (opcode_i == `OPC_SPARE_NOP ||
                opcode_i == `OPC_NO_OPERATION) begin
                // Spare opcode shares the no-operation path exactly
                no_operation_o <= 1'b1;
            end else if (is_paged) begin
                branch_valid_o   <= 1'b1;
                branch_is_call_o <= opcode_i[`PAGED_CALL_BIT];
                branch_target_o  <= paged_target;
            end else if (is_long) begin
                branch_valid_o   <= 1'b1;
                branch_is_call_o <= (opcode_i == `OPC_LONG_CALL);
                branch_target_o  <= long_target;
            end else begin
                if (is_rel) begin
                    branch_valid_o  <= 1'b1;
                    branch_target_o <= rel_target;
                end
                if (is_bank_reg(opcode_i)) begin
                    operand_kind_o <= `KIND_BANK_REG;
                    // Bank base is bank number times eight
                    operand_addr_o <= {3'b000, bank_select_i,
                                       opcode_i[2:0]};
                end else if (is_indirect(opcode_i)) begin
                    operand_kind_o <= `KIND_INDIRECT;
                    operand_addr_o <= opcode_i[0] ? pointer_r1_i
                                                  : pointer_r0_i;
                end else if (is_bit_op(opcode_i)) begin
                    operand_kind_o <= `KIND_BIT;
                    operand_addr_o <= bit_byte_addr(operand1_i);
                    operand_bit_o  <= operand1_i[2:0];
                end else if (opcode_i[3:0] == 4'h5) begin
                    // Direct address splits RAM from the SFR space
                    operand_kind_o <= (operand1_i < `SFR_SPACE_BASE)
                                    ? `KIND_DIRECT_RAM
                                    : `KIND_DIRECT_SFR;
                    operand_addr_o <= operand1_i;
                end
            end
        end
    end

endmodule

// [src/operand_addressing_defs.vh]
// Constants shared by the operand addressing logic
`ifndef OPERAND_ADDRESSING_DEFS_VH
`define OPERAND_ADDRESSING_DEFS_VH

// ==========================================================
// Special-function addresses
`define DATA_POINTER_LOW_ADDR   8'h82
`define DATA_POINTER_HIGH_ADDR  8'h83
`define DATA_POINTER_RESET      8'h00
`define SFR_SPACE_BASE          8'h80

// ==========================================================
// Opcodes and opcode fields
`define OPC_NO_OPERATION        8'h00
`define OPC_SPARE_NOP           8'ha5
`define OPC_SHORT_JUMP          8'h80
`define OPC_LONG_JUMP           8'h02
`define OPC_LONG_CALL           8'h12
`define OPC_JUMP_IF_CARRY       8'h40
`define OPC_JUMP_NOT_CARRY      8'h50
`define OPC_JUMP_IF_ZERO        8'h60
`define OPC_JUMP_NOT_ZERO       8'h70
`define OPC_DEC_JUMP_DIRECT     8'hd5
`define OPC_JUMP_BIT_SET        8'h20
`define OPC_JUMP_BIT_CLEAR      8'h30
`define OPC_JUMP_BIT_CLEAR_SET  8'h10
`define PAGED_LOW_NIBBLE        4'h1
`define PAGED_CALL_BIT          4
`define OPC_CARRY_OR_NOT_BIT    8'ha0
`define OPC_CARRY_AND_NOT_BIT   8'hb0
`define BIT_OP_LOW_NIBBLE       4'h2
`define BIT_OP_ROW_FIRST        4'h7
`define BIT_OP_ROW_LAST         4'hd

// ==========================================================
// Operand kinds reported on operand_kind_o
`define KIND_NONE               3'h0
`define KIND_BANK_REG           3'h1
`define KIND_INDIRECT           3'h2
`define KIND_DIRECT_RAM         3'h3
`define KIND_DIRECT_SFR         3'h4
`define KIND_BIT                3'h5

`endif

// [testbench/cpu_operand_addressing_tb_top.sv]
// Self-checking testbench for the operand addressing block
`include "operand_addressing_defs.vh"
module cpu_operand_addressing_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  opcode_i = 8'h00, operand1_i = 8'h00, operand2_i = 8'h00;
    logic [7:0]  pointer_r0_i = 8'h44, pointer_r1_i = 8'hc7;
    logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
    logic [15:0] next_pc_i = 16'h0000;
    logic [1:0]  bank_select_i = 2'h0;
    logic [3:0]  sfr_page_i = 4'h0;
    logic        sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
    logic [7:0]  sfr_rdata_o, operand_addr_o;
    logic [2:0]  operand_kind_o, operand_bit_o;
    logic        sfr_hit_o, no_operation_o, branch_valid_o, branch_is_call_o;
    logic [15:0] branch_target_o, data_pointer_o;
    int          n_errors = 0;
    int          cmp_count = 0;
    cpu_operand_addressing u_cpu_operand_addressing (.*);
    always #12.5 clock_i = ~clock_i;
    // =========================================================
    // Tasks
    task automatic check(input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d, input logic [3:0] pg);
        @(posedge clock_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_page_i <= pg;
        sfr_wr_i <= 1'b1;
        @(posedge clock_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp, input logic hit);
        @(posedge clock_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge clock_i);
        sfr_rd_i <= 1'b0;
        #1;
        check(sfr_rdata_o, exp);
        check(sfr_hit_o, hit);
    endtask
    task automatic dec(input logic [7:0] op, a, b, input logic [15:0] pc);
        @(posedge clock_i);
        opcode_i <= op;
        operand1_i <= a;
        operand2_i <= b;
        next_pc_i <= pc;
        @(posedge clock_i);
        #1;
    endtask
    task automatic br(input logic [7:0] op, a, b, input logic [15:0] pc, t,
                      input logic call);
        dec(op, a, b, pc);
        check(branch_valid_o, 1'b1);
        check(branch_target_o, t);
        check(branch_is_call_o, call);
    endtask
    task automatic kd(input logic [7:0] op, a, input logic [2:0] k,
                      input logic [7:0] ad);
        dec(op, a, 8'h00, 16'h0000);
        check(operand_kind_o, k);
        check(operand_addr_o, ad);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // =========================================================
    // Tests
    initial begin
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(8'h82, 8'h00, 1'b1);
        rd(8'h83, 8'h00, 1'b1);
        check(no_operation_o, 1'b1);
        $display("test reset done");
        wr(8'h82, 8'h5a, 4'h0);
        wr(8'h83, 8'hc3, 4'hf);
        wr(8'h81, 8'hff, 4'h3);
        #1;
        check(data_pointer_o, 16'hc35a);
        // Miss right after a hit: zero must replace the old read data
        rd(8'h82, 8'h5a, 1'b1);
        rd(8'h81, 8'h00, 1'b0);
        rd(8'h83, 8'hc3, 1'b1);
        $display("test data pointer done");
        br(8'h80, 8'hfe, 8'h00, 16'h0102, 16'h0100, 1'b0);
        br(8'h80, 8'h7f, 8'h00, 16'hffff, 16'h007e, 1'b0);
        br(8'h40, 8'h80, 8'h00, 16'h1000, 16'h0f80, 1'b0);
        br(8'h20, 8'h21, 8'h10, 16'h2000, 16'h2010, 1'b0);
        br(8'h02, 8'h12, 8'h34, 16'h0003, 16'h1234, 1'b0);
        br(8'h12, 8'hab, 8'hcd, 16'h0003, 16'habcd, 1'b1);
        br(8'hf1, 8'h55, 8'h00, 16'h8802, 16'h8f55, 1'b1);
        br(8'h01, 8'h55, 8'h00, 16'hfffe, 16'hf855, 1'b0);
        dec(8'ha5, 8'h12, 8'h34, 16'h0100);
        check(no_operation_o, 1'b1);
        check(branch_valid_o, 1'b0);
        @(posedge clock_i);
        bank_select_i <= 2'h2;
        kd(8'he9, 8'h00, `KIND_BANK_REG, 8'h11);
        kd(8'he6, 8'h00, `KIND_INDIRECT, 8'h44);
        kd(8'he7, 8'h00, `KIND_INDIRECT, 8'hc7);
        kd(8'he5, 8'h30, `KIND_DIRECT_RAM, 8'h30);
        kd(8'he5, 8'h82, `KIND_DIRECT_SFR, 8'h82);
        kd(8'h25, 8'h90, `KIND_DIRECT_SFR, 8'h90);
        kd(8'h72, 8'hd7, `KIND_BIT, 8'hd0);
        check(operand_bit_o, 3'h7);
        kd(8'hd2, 8'h0b, `KIND_BIT, 8'h21);
        check(operand_bit_o, 3'h3);
        $display("test decode done");
        close_out;
    end
    // Generous bound: the sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clock_i);
        n_errors++;
        close_out;
    end
endmodule

// [testbench/operand_addressing_props.sv]
// Checker for operand decode, branch targets and data pointer registers
`include "operand_addressing_defs.vh"
module operand_addressing_props #(
    parameter PC_WIDTH = 16
) (
    input wire                clock_i,
    input wire                sys_rst_i,
    input wire [7:0]          opcode_i,
    input wire [7:0]          operand1_i,
    input wire [7:0]          operand2_i,
    input wire [PC_WIDTH-1:0] next_pc_i,
    input wire [1:0]          bank_select_i,
    input wire [7:0]          sfr_addr_i,
    input wire [7:0]          sfr_wdata_i,
    input wire                sfr_wr_i,
    input wire                sfr_rd_i,
    input wire [7:0]          sfr_rdata_o,
    input wire                sfr_hit_o,
    input wire [2:0]          operand_kind_o,
    input wire [7:0]          operand_addr_o,
    input wire                no_operation_o,
    input wire                branch_valid_o,
    input wire                branch_is_call_o,
    input wire [PC_WIDTH-1:0] branch_target_o,
    input wire [15:0]         data_pointer_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // =========================================================
    // Helpers
    wire        dp_sel    = sfr_addr_i[7:1] == 7'h41;
    wire [15:0] rel_sum   = next_pc_i + {{8{operand1_i[7]}}, operand1_i};
    wire [15:0] paged_sum = {next_pc_i[15:11], opcode_i[7:5], operand1_i};
    wire [15:0] long_sum  = {operand1_i, operand2_i};
    // =========================================================
    // Properties
    a_low_write: assert property (
        sfr_wr_i && sfr_addr_i == 8'h82 |=>
        data_pointer_o[7:0] == $past(sfr_wdata_i)) else $error("low byte");
    a_high_write: assert property (
        sfr_wr_i && sfr_addr_i == 8'h83 |=>
        data_pointer_o[15:8] == $past(sfr_wdata_i)) else $error("high byte");
    a_pointer_hold: assert property (
        !(sfr_wr_i && dp_sel) |=> $stable(data_pointer_o))
        else $error("pointer changed");
    a_read_hit: assert property (
        sfr_rd_i |=> sfr_hit_o == $past(dp_sel)
        && (sfr_hit_o || sfr_rdata_o == 8'h00)) else $error("read answer");
    a_rel_target: assert property (
        opcode_i == `OPC_SHORT_JUMP |=>
        branch_valid_o && branch_target_o == $past(rel_sum))
        else $error("relative target");
    a_paged_target: assert property (
        opcode_i[3:0] == 4'h1 |=>
        branch_target_o == $past(paged_sum)
        && branch_is_call_o == $past(opcode_i[4]))
        else $error("paged target");
    a_long_target: assert property (
        opcode_i == `OPC_LONG_CALL |=>
        branch_is_call_o && branch_target_o == $past(long_sum))
        else $error("long target");
    a_spare_nop: assert property (
        opcode_i == `OPC_SPARE_NOP |=> no_operation_o
        && !branch_valid_o && operand_kind_o == `KIND_NONE)
        else $error("spare");
    a_direct_split: assert property (
        operand_kind_o == `KIND_DIRECT_RAM |-> !operand_addr_o[7])
        else $error("direct ram range");
    a_bank_range: assert property (
        operand_kind_o == `KIND_BANK_REG |->
        operand_addr_o == {3'h0, $past(bank_select_i), $past(opcode_i[2:0])})
        else $error("bank range");
endmodule
bind cpu_operand_addressing operand_addressing_props #(.PC_WIDTH(PC_WIDTH))
    u_operand_addressing_props (.*);
